// >>> wepsc_pkg.sv
`default_nettype none
package wepsc_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_HZ      = 10_000_000;
    localparam int BTN_SHORT_S = 4;
    localparam int BTN_LONG_S  = 6;
    localparam int BLINK_MS    = 500;
    localparam int BTN_SHORT_CYC = BTN_SHORT_S * CLK_HZ;
    localparam int BTN_LONG_CYC  = BTN_LONG_S * CLK_HZ;
    localparam int BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);
    localparam int BTN_CNT_W     = 26;
    localparam int BLINK_CNT_W   = 23;

    // ************************************************************
    // Wake sources, one bit each in status, mask and enable
    // ************************************************************
    localparam int NSRC       = 8;
    localparam int SRC_BTN    = 0;
    localparam int SRC_RTC    = 1;
    localparam int SRC_LAN    = 2;
    localparam int SRC_PME    = 3;
    localparam int SRC_PCIE   = 4;
    localparam int SRC_USB    = 5;
    localparam int SRC_SERIAL = 6;
    localparam int SRC_PS2    = 7;
    localparam int NFAN       = 3;

    // ************************************************************
    // Register map, byte addresses
    // ************************************************************
    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_CMD   = 8'h00;
    localparam logic [7:0] ADR_CFG   = 8'h04;
    localparam logic [7:0] ADR_STAT  = 8'h08;
    localparam logic [7:0] ADR_WSTAT = 8'h0c;
    localparam logic [7:0] ADR_WMASK = 8'h10;
    localparam logic [7:0] ADR_WEN   = 8'h14;

    // Command field codes; code 2'h0 does nothing, S1 has no code.
    localparam logic [1:0] CMD_S3 = 2'h1;
    localparam logic [1:0] CMD_S4 = 2'h2;
    localparam logic [1:0] CMD_S5 = 2'h3;

    // Configuration fields.
    localparam int CFG_W         = 3;
    localparam int CFG_BTN_SLEEP = 2;
    localparam logic [1:0] LED_OFF   = 2'h0;
    localparam logic [1:0] LED_ON    = 2'h1;
    localparam logic [1:0] LED_BLINK = 2'h2;
    localparam logic [2:0] CFG_RST   = 3'h0;
    localparam logic [7:0] WEN_RST   = 8'hff;
    localparam logic [7:0] WMASK_RST = 8'h00;

    // AC-return policy codes on the policy pins.
    localparam logic [1:0] POL_OFF = 2'h0;
    localparam logic [1:0] POL_ON  = 2'h1;

    // Power states, Gray coded along S5 -> S0 -> S3 -> S4.
    typedef enum logic [1:0] {
        ST_S5 = 2'b00,
        ST_S0 = 2'b01,
        ST_S3 = 2'b11,
        ST_S4 = 2'b10
    } wepsc_state_t;

endpackage
`default_nettype wire

// >>> wepsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wepsc_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    // ************************************************************
    // Two-stage synchronisers, one per bit
    // ************************************************************
    logic [W-1:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // The first stage feeds only the second stage.
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_r[g] <= 1'b0;
                    q_o[g]    <= 1'b0;
                end else begin
                    meta_r[g] <= d_i[g];
                    q_o[g]    <= meta_r[g];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> wepsc_btn_timer.sv
`timescale 1ns/1ps
`default_nettype none
module wepsc_btn_timer
    import wepsc_pkg::*;
#(
    parameter int SHORT_CYC = BTN_SHORT_CYC,
    parameter int LONG_CYC  = BTN_LONG_CYC
) (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic pressed_i,
    output logic      short_o,
    output logic      long_o
);

    // ************************************************************
    // Press duration counter
    // ************************************************************
    logic [BTN_CNT_W-1:0] cnt_r;
    logic [BTN_CNT_W-1:0] cnt_nxt;
    logic                 prev_r;
    logic                 short_nxt;
    logic                 long_nxt;

    // The counter saturates so a stuck button never wraps into a
    // false short press; holds between the two limits do nothing.
    always_comb begin
        cnt_nxt   = cnt_r;
        short_nxt = 1'b0;
        long_nxt  = 1'b0;
        if (pressed_i) begin
            if (cnt_r != BTN_CNT_W'(LONG_CYC)) begin
                cnt_nxt = cnt_r + 1'b1;
            end
            if (cnt_r == BTN_CNT_W'(LONG_CYC - 1)) begin
                long_nxt = 1'b1;
            end
        end else begin
            cnt_nxt = '0;
            if (prev_r && cnt_r < BTN_CNT_W'(SHORT_CYC)) begin
                short_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r   <= '0;
            prev_r  <= 1'b0;
            short_o <= 1'b0;
            long_o  <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            prev_r  <= pressed_i;
            short_o <= short_nxt;
            long_o  <= long_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> wepsc_ctrl.sv
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wepsc_ctrl
    import wepsc_pkg::*;
#(
    parameter int SHORT_CYCLES = BTN_SHORT_CYC,
    parameter int LONG_CYCLES  = BTN_LONG_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             pwr_btn_n_i,
    input  wire logic             rtc_alarm_i,
    input  wire logic             lan_wake_i,
    input  wire logic             pci_pme_n_i,
    input  wire logic             pcie_wake_n_i,
    input  wire logic             usb_act_i,
    input  wire logic             serial_act_i,
    input  wire logic             ps2_act_i,
    input  wire logic             ps2_hotkey_i,
    input  wire logic [1:0]       ac_policy_i,
    input  wire logic             last_on_i,
    output logic                  psu_on_o,
    output logic      [NFAN-1:0]  fan_en_o,
    output logic                  usb_pwr_o,
    output logic                  pwr_led_o,
    output logic                  last_on_o,
    output logic                  irq_o
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    // Byte-enable expansion for partial writes.
    function automatic logic [31:0] sel_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // Wake sources that each power state listens to.
    function automatic logic [NSRC-1:0] src_allowed(input wepsc_state_t s);
        logic [NSRC-1:0] a;
        a = '0;
        case (s)
            ST_S3: begin
                a = '1;
            end
            ST_S4, ST_S5: begin
                a = '1;
                a[SRC_USB]    = 1'b0;
                a[SRC_SERIAL] = 1'b0;
            end
            default: begin
                a = '0;
            end
        endcase
        return a;
    endfunction

    // ************************************************************
    // Input synchronisation and press timing
    // ************************************************************
    logic [NSRC:0] raw_in;
    logic [NSRC:0] sync_in;
    logic [NSRC:0] prev_r;
    logic          btn_short;
    logic          btn_long;

    // Active-low pins are inverted ahead of the synchroniser.
    assign raw_in = {ps2_hotkey_i, ps2_act_i, serial_act_i, usb_act_i,
                     ~pcie_wake_n_i, ~pci_pme_n_i, lan_wake_i,
                     rtc_alarm_i, ~pwr_btn_n_i};

    wepsc_sync #(
        .W (NSRC + 1)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .d_i       (raw_in),
        .q_o       (sync_in)
    );

    wepsc_btn_timer #(
        .SHORT_CYC (SHORT_CYCLES),
        .LONG_CYC  (LONG_CYCLES)
    ) u_btn (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .pressed_i (sync_in[SRC_BTN]),
        .short_o   (btn_short),
        .long_o    (btn_long)
    );

    // ************************************************************
    // Wake event qualification
    // ************************************************************
    wepsc_state_t    state_r;
    wepsc_state_t    state_nxt;
    logic [NSRC-1:0] edge_ev;
    logic [NSRC-1:0] wake_ev;
    logic            ps2_ok;

    // Sources wake on the rising edge of their active level; the
    // button instead wakes on a completed short press.
    always_comb begin
        edge_ev          = sync_in[NSRC-1:0] & ~prev_r[NSRC-1:0];
        edge_ev[SRC_BTN] = btn_short;
        ps2_ok = (state_r == ST_S3) || sync_in[NSRC];
        edge_ev[SRC_PS2] = edge_ev[SRC_PS2] & ps2_ok;
        wake_ev = edge_ev & src_allowed(state_r);
    end

    // ************************************************************
    // Wishbone register file
    // ************************************************************
    logic                 ack_r;
    logic                 ack_nxt;
    logic [31:0]          dat_r;
    logic [31:0]          dat_nxt;
    logic [CFG_W-1:0]     cfg_r;
    logic [CFG_W-1:0]     cfg_nxt;
    logic [NSRC-1:0]      wstat_r;
    logic [NSRC-1:0]      wstat_nxt;
    logic [NSRC-1:0]      wmask_r;
    logic [NSRC-1:0]      wmask_nxt;
    logic [NSRC-1:0]      wen_r;
    logic [NSRC-1:0]      wen_nxt;
    logic [1:0]           cmd_nxt;
    logic                 irq_nxt;
    logic                 acc;
    logic [31:0]          wm;
    logic [31:0]          wv;

    // One access per ack; ack drops in the cycle after it is given,
    // so a request made while ack is low answers on the first edge after it; one made in the ack cycle waits one more edge.
    always_comb begin
        acc       = wb_cyc_i && wb_stb_i && !ack_r;
        ack_nxt   = acc;
        dat_nxt   = '0;
        cfg_nxt   = cfg_r;
        wmask_nxt = wmask_r;
        wen_nxt   = wen_r;
        cmd_nxt   = 2'h0;
        wm        = sel_mask(wb_sel_i);
        wv        = wb_dat_i & wm;
        wstat_nxt = wstat_r;
        if (acc && wb_we_i) begin
            case (wb_adr_i)
                ADR_CMD:   cmd_nxt   = wv[1:0];
                ADR_CFG:   cfg_nxt   = (cfg_r & ~wm[CFG_W-1:0])
                                       | wv[CFG_W-1:0];
                ADR_WSTAT: wstat_nxt = wstat_r & ~wv[NSRC-1:0];
                ADR_WMASK: wmask_nxt = (wmask_r & ~wm[NSRC-1:0])
                                       | wv[NSRC-1:0];
                ADR_WEN:   wen_nxt   = (wen_r & ~wm[NSRC-1:0])
                                       | wv[NSRC-1:0];
                default:   cmd_nxt   = 2'h0;
            endcase
        end else if (acc) begin
            case (wb_adr_i)
                ADR_CFG:   dat_nxt[CFG_W-1:0] = cfg_r;
                ADR_STAT:  dat_nxt[1:0]       = state_r;
                ADR_WSTAT: dat_nxt[NSRC-1:0]  = wstat_r;
                ADR_WMASK: dat_nxt[NSRC-1:0]  = wmask_r;
                ADR_WEN:   dat_nxt[NSRC-1:0]  = wen_r;
                default:   dat_nxt            = '0;
            endcase
        end
        // A new event outranks a write-one-to-clear in the same cycle.
        wstat_nxt = wstat_nxt | wake_ev;
        irq_nxt   = |(wstat_nxt & wmask_nxt);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_r   <= 1'b0;
            dat_r   <= '0;
            cfg_r   <= CFG_RST;
            wstat_r <= '0;
            wmask_r <= WMASK_RST;
            wen_r   <= WEN_RST;
            irq_o   <= 1'b0;
            prev_r  <= '0;
        end else begin
            ack_r   <= ack_nxt;
            dat_r   <= dat_nxt;
            cfg_r   <= cfg_nxt;
            wstat_r <= wstat_nxt;
            wmask_r <= wmask_nxt;
            wen_r   <= wen_nxt;
            irq_o   <= irq_nxt;
            prev_r  <= sync_in;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ************************************************************
    // Power state machine
    // ************************************************************
    logic boot_r;
    logic boot_nxt;
    logic wake_go;

    // The first cycle after reset settles the state from the stored
    // policy; the pins are read here and never under the reset.
    always_comb begin
        state_nxt = state_r;
        boot_nxt  = 1'b0;
        wake_go   = |(wake_ev & wen_r);
        if (boot_r) begin
            case (ac_policy_i)
                POL_OFF: state_nxt = ST_S5;
                POL_ON:  state_nxt = ST_S0;
                default: state_nxt = last_on_i ? ST_S0 : ST_S5;
            endcase
        end else begin
            case (state_r)
                ST_S0: begin
                    if (btn_long) begin
                        state_nxt = ST_S5;
                    end else if (btn_short) begin
                        state_nxt = cfg_r[CFG_BTN_SLEEP] ? ST_S3 : ST_S5;
                    end else begin
                        case (cmd_nxt)
                            CMD_S3:  state_nxt = ST_S3;
                            CMD_S4:  state_nxt = ST_S4;
                            CMD_S5:  state_nxt = ST_S5;
                            default: state_nxt = ST_S0;
                        endcase
                    end
                end
                ST_S3, ST_S4: begin
                    if (btn_long) begin
                        state_nxt = ST_S5;
                    end else if (wake_go) begin
                        state_nxt = ST_S0;
                    end
                end
                ST_S5: begin
                    if (wake_go) begin
                        state_nxt = ST_S0;
                    end
                end
                default: state_nxt = ST_S5;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_S5;
            boot_r  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            boot_r  <= boot_nxt;
        end
    end

    // ************************************************************
    // Rail, fan, USB and indicator outputs
    // ************************************************************
    logic [BLINK_CNT_W-1:0] blink_cnt_r;
    logic [BLINK_CNT_W-1:0] blink_cnt_nxt;
    logic                   blink_r;
    logic                   blink_nxt;
    logic                   psu_nxt;
    logic [NFAN-1:0]        fan_nxt;
    logic                   usb_nxt;
    logic                   led_nxt;
    logic                   on_now;

    // Outputs follow the next state so they move with the state
    // register rather than one cycle behind it.
    always_comb begin
        blink_cnt_nxt = blink_cnt_r + 1'b1;
        blink_nxt     = blink_r;
        if (blink_cnt_r == BLINK_CNT_W'(BLINK_CYCLES - 1)) begin
            blink_cnt_nxt = '0;
            blink_nxt     = ~blink_r;
        end
        on_now  = (state_nxt == ST_S0);
        psu_nxt = on_now;
        fan_nxt = {NFAN{on_now}};
        usb_nxt = on_now || (state_nxt == ST_S3);
        led_nxt = on_now;
        if (state_nxt == ST_S3) begin
            case (cfg_r[1:0])
                LED_ON:    led_nxt = 1'b1;
                LED_BLINK: led_nxt = blink_r;
                LED_OFF:   led_nxt = 1'b0;
                default:   led_nxt = 1'b0;
            endcase
        end
    end

    // During the settle cycle everything stays off.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
            psu_on_o    <= 1'b0;
            fan_en_o    <= '0;
            usb_pwr_o   <= 1'b0;
            pwr_led_o   <= 1'b0;
            last_on_o   <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            blink_r     <= blink_nxt;
            psu_on_o    <= psu_nxt;
            fan_en_o    <= fan_nxt;
            usb_pwr_o   <= usb_nxt;
            pwr_led_o   <= led_nxt;
            last_on_o   <= on_now;
        end
    end

endmodule
`default_nettype wire

// >>> wepsc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Supply and network card model
// ********************
module wepsc_far_model (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic frame_seen_i,
    input  wire logic psu_on_i,
    output logic      lan_wake_o,
    output logic      rail_main_o
);
    logic lan_nxt;
    logic rail_nxt;

    // The card raises wake one cycle after it has seen a wake frame.
    // The supply drops its main rail whenever it is told to go off.
    always_comb begin
        lan_nxt  = frame_seen_i;
        rail_nxt = psu_on_i;
    end

    // Register the model outputs; both are low in reset.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lan_wake_o  <= 1'b0;
            rail_main_o <= 1'b0;
        end else begin
            lan_wake_o  <= lan_nxt;
            rail_main_o <= rail_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> wepsc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Port checker
// ********************
module wepsc_ctrl_props
    import wepsc_pkg::*;
(
    input wire logic            clk_sys_i,
    input wire logic            rstn_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire logic            pci_pme_n_i,
    input wire logic            pcie_wake_n_i,
    input wire logic            psu_on_o,
    input wire logic [NFAN-1:0] fan_en_o,
    input wire logic            usb_pwr_o,
    input wire logic            last_on_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // A wake line falling while asleep must bring the supply up soon.
    sequence s_pme_asleep;
        $fell(pci_pme_n_i) && !psu_on_o;
    endsequence
    sequence s_pcie_asleep;
        $fell(pcie_wake_n_i) && !psu_on_o;
    endsequence
    sequence s_woken;
        ##[1:6] psu_on_o;
    endsequence

    a_fans_track_psu:
        assert property (fan_en_o == {NFAN{psu_on_o}})
        else $error("fans differ from supply state");
    a_usb_with_psu:
        assert property (psu_on_o |-> usb_pwr_o)
        else $error("usb power off while working");
    a_last_on_track:
        assert property (last_on_o == psu_on_o)
        else $error("stored state differs from supply");
    a_pme_wakes:
        assert property (s_pme_asleep |-> s_woken)
        else $error("pme did not wake");
    a_pcie_wakes:
        assert property (s_pcie_asleep |-> s_woken)
        else $error("pcie wake did not wake");
    a_ack_single:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answers:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_caused:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_quiet:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
endmodule

bind wepsc_ctrl wepsc_ctrl_props wepsc_ctrl_props_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pci_pme_n_i(pci_pme_n_i), .pcie_wake_n_i(pcie_wake_n_i),
    .psu_on_o(psu_on_o), .fan_en_o(fan_en_o), .usb_pwr_o(usb_pwr_o),
    .last_on_o(last_on_o)
);
`default_nettype wire

// >>> wepsc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Bench top
// ********************
module wepsc_ctrl_bench;
    import wepsc_pkg::*;
    logic            clk_sys_i = 1'b0;
    logic            rstn_i    = 1'b0;
    logic            wb_cyc_i  = 1'b0;
    logic            wb_stb_i  = 1'b0;
    logic            wb_we_i   = 1'b0;
    logic [7:0]      wb_adr_i  = 8'h00;
    logic [31:0]     wb_dat_i  = 32'h0;
    logic [7:0]      act       = 8'h00;
    logic            hk        = 1'b0;
    logic [1:0]      pol       = POL_ON;
    logic            lst       = 1'b0;
    logic [31:0]     wb_dat_o;
    logic            wb_ack_o;
    logic            lan;
    logic            psu_on_o;
    logic            rail;
    logic [NFAN-1:0] fan_en_o;
    logic            usb_pwr_o;
    logic            pwr_led_o;
    logic            irq_o;
    int              fails     = 0;
    int              n_tests   = 0;

    // Short counts keep the button scenarios brief.
    wepsc_ctrl #(.SHORT_CYCLES(20), .LONG_CYCLES(40), .BLINK_CYCLES(4))
    wepsc_ctrl_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pwr_btn_n_i(~act[SRC_BTN]),
        .rtc_alarm_i(act[SRC_RTC]), .lan_wake_i(lan),
        .pci_pme_n_i(~act[SRC_PME]), .pcie_wake_n_i(~act[SRC_PCIE]),
        .usb_act_i(act[SRC_USB]), .serial_act_i(act[SRC_SERIAL]),
        .ps2_act_i(act[SRC_PS2]), .ps2_hotkey_i(hk),
        .ac_policy_i(pol), .last_on_i(lst), .psu_on_o(psu_on_o),
        .fan_en_o(fan_en_o), .usb_pwr_o(usb_pwr_o),
        .pwr_led_o(pwr_led_o), .last_on_o(), .irq_o(irq_o)
    );

    // The network card and supply on the far side.
    wepsc_far_model wepsc_far_model_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .frame_seen_i(act[SRC_LAN]), .psu_on_i(psu_on_o),
        .lan_wake_o(lan), .rail_main_o(rail)
    );

    // The clock runs at 10 MHz.
    always #50 clk_sys_i = ~clk_sys_i;

    task automatic give_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is seen.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: no ack", $time);
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic pulse(input int src, input int len);
        @(posedge clk_sys_i);
        act[src] <= 1'b1;
        go(len);
        act[src] <= 1'b0;
    endtask

    // Reset values, an unmapped place and the idle command code.
    task automatic t_regs();
        rd(ADR_STAT, {30'h0, ST_S0});
        rd(ADR_CFG, {29'h0, CFG_RST});
        rd(ADR_WEN, {24'h0, WEN_RST});
        rd(ADR_WMASK, {24'h0, WMASK_RST});
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        wr(ADR_CMD, 32'h0);
        rd(ADR_STAT, {30'h0, ST_S0});
    endtask

    // Sleep, try one source, judge the outcome and get back to work.
    task automatic attempt(input logic [1:0] cmd, input int src,
                           input logic hot, input logic exp);
        logic [1:0] st;
        st = (cmd == CMD_S3) ? ST_S3 : (cmd == CMD_S4) ? ST_S4 : ST_S5;
        wr(ADR_CMD, {30'h0, cmd});
        go(5);
        rd(ADR_STAT, {30'h0, st});
        chk({25'h0, pwr_led_o, fan_en_o, usb_pwr_o, psu_on_o, rail},
            {26'h0, 3'h0, cmd == CMD_S3, 2'h0});
        hk <= hot;
        pulse(src, 4);
        go(8);
        chk({28'h0, psu_on_o, fan_en_o}, {28'h0, {4{exp}}});
        rd(ADR_WSTAT, exp ? (32'h1 << src) : 32'h0);
        chk({31'h0, irq_o}, {31'h0, exp});
        wr(ADR_WSTAT, 32'hff);
        hk <= 1'b0;
        if (!exp) begin
            pulse(SRC_BTN, 4);
            go(8);
            chk({31'h0, psu_on_o}, 32'h1);
            wr(ADR_WSTAT, 32'hff);
        end
    endtask

    task automatic t_table();
        wr(ADR_WMASK, 32'hff);
        attempt(CMD_S3, SRC_USB, 1'b0, 1'b1);
        attempt(CMD_S4, SRC_USB, 1'b0, 1'b0);
        attempt(CMD_S3, SRC_SERIAL, 1'b0, 1'b1);
        attempt(CMD_S5, SRC_SERIAL, 1'b0, 1'b0);
        attempt(CMD_S3, SRC_PS2, 1'b0, 1'b1);
        attempt(CMD_S4, SRC_PS2, 1'b0, 1'b0);
        attempt(CMD_S5, SRC_PS2, 1'b1, 1'b1);
        attempt(CMD_S4, SRC_LAN, 1'b0, 1'b1);
        attempt(CMD_S5, SRC_RTC, 1'b0, 1'b1);
        attempt(CMD_S3, SRC_BTN, 1'b0, 1'b1);
        attempt(CMD_S4, SRC_PME, 1'b0, 1'b1);
        attempt(CMD_S5, SRC_PCIE, 1'b0, 1'b1);
    endtask

    // A masked flag keeps the line low until it is unmasked.
    task automatic t_irq();
        wr(ADR_WMASK, 32'h0);
        wr(ADR_CMD, {30'h0, CMD_S3});
        pulse(SRC_RTC, 4);
        go(8);
        chk({31'h0, irq_o}, 32'h0);
        rd(ADR_WSTAT, 32'h1 << SRC_RTC);
        wr(ADR_WMASK, 32'hff);
        go(2);
        chk({31'h0, irq_o}, 32'h1);
        wr(ADR_WSTAT, 32'h1 << SRC_RTC);
        go(2);
        chk({31'h0, irq_o}, 32'h0);
    endtask

    // Short presses toggle by option, a long one forces soft-off.
    task automatic t_button();
        logic led;
        wr(ADR_CFG, 32'h5);
        pulse(SRC_BTN, 4);
        go(8);
        rd(ADR_STAT, {30'h0, ST_S3});
        chk({31'h0, pwr_led_o}, 32'h1);
        // Blinking flips the indicator once per blink period.
        wr(ADR_CFG, 32'h6);
        go(1);
        led = pwr_led_o;
        go(4);
        chk({31'h0, pwr_led_o}, {31'h0, ~led});
        pulse(SRC_BTN, 4);
        go(8);
        rd(ADR_STAT, {30'h0, ST_S0});
        wr(ADR_CFG, 32'h0);
        pulse(SRC_BTN, 4);
        go(8);
        rd(ADR_STAT, {30'h0, ST_S5});
        pulse(SRC_BTN, 4);
        go(8);
        pulse(SRC_BTN, 50);
        go(8);
        rd(ADR_STAT, {30'h0, ST_S5});
    endtask

    // Reset in mid-run with the policy pins set, then the settled state.
    task automatic t_ac(input logic [1:0] p, input logic l,
                        input logic [1:0] st);
        pol    <= p;
        lst    <= l;
        rstn_i <= 1'b0;
        go(2);
        rstn_i <= 1'b1;
        go(2);
        chk({31'h0, psu_on_o}, {31'h0, st == ST_S0});
        rd(ADR_STAT, {30'h0, st});
    endtask

    // Hold reset for five cycles, then run every scenario.
    initial begin
        go(5);
        rstn_i <= 1'b1;
        go(2);
        t_regs();
        t_table();
        t_irq();
        t_button();
        t_ac(2'h2, 1'b1, ST_S0);
        t_ac(2'h3, 1'b0, ST_S5);
        t_ac(POL_OFF, 1'b1, ST_S5);
        give_verdict();
    end
endmodule
`default_nettype wire
